// ---- vram_refresh_pkg.sv ----
package vram_refresh_pkg;

    // Array geometry
    localparam int ROW_COUNT = 512;
    localparam int ROW_WIDTH = 9;

    // Refresh period in microseconds and clock rate
    localparam int REFRESH_PERIOD_US = 8000;
    localparam int CLK_MHZ = 125;
    // Longest time rounds down: interval between row refreshes
    localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_US * CLK_MHZ;
    localparam int ROW_INTERVAL_CYC = REFRESH_PERIOD_CYC / ROW_COUNT;

    // Strobe phase minimums in ns, rounded up to cycles
    localparam int CLK_NS = 8;
    localparam int SETUP_NS = 10;
    localparam int RAS_PULSE_NS = 100;
    localparam int RAS_PRECHARGE_NS = 70;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_PULSE_CYC = (RAS_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_PRECHARGE_CYC = (RAS_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;

    // Address bit positions of the boundary code
    localparam int BOUNDARY_LSB = 2;
    localparam int BOUNDARY_WIDTH = 5;

    // Refresh flavours the user may request
    typedef enum logic [1:0] {
        MODE_ROW_ONLY = 2'h0,
        MODE_PLAIN_COUNTER = 2'h1,
        MODE_CLEARING_COUNTER = 2'h2,
        MODE_BOUNDARY_SETTING = 2'h3
    } refresh_mode_t;

    // Strobe pins toward the memory, all active low except function select
    typedef struct packed {
        logic row_strobe_n;
        logic column_strobe_n;
        logic transfer_or_output_enable_n;
        logic upper_byte_write_n;
        logic lower_byte_write_n;
        logic function_select;
    } strobe_pins_t;

    localparam strobe_pins_t PINS_IDLE = 6'h3E;

endpackage : vram_refresh_pkg

// ---- phase_timer.sv ----
`timescale 1ns/100ps
// Down-counter that holds a strobe phase for a programmed number of cycles
module phase_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);
    // Remaining cycles of the current phase
    logic [WIDTH-1:0] left_ff;

    // Reload on request, otherwise count down to zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            left_ff <= '0;
        else if (load)
            left_ff <= count;
        else if (left_ff != '0)
            left_ff <= left_ff - WIDTH'(1);
    end

    // Done looks at the count alone: the sequencer derives load from done, so a load term would close a loop
    assign done = (left_ff == '0);
endmodule : phase_timer

// ---- vram_refresh_ctrl.sv ----
`timescale 1ns/100ps
// How it works
// R1 - Refresh all 512 rows every 8 ms
// R2 - User traffic row strobes count as refresh
// R3 - Row-only: present row, column strobe high
// R4 - Row-only: output enable high at fall
// R5 - Column-before-row uses device counter, no address
// R6 - Counter refresh: device floats outputs
// R7 - Hidden refresh: re-pulse row strobe after read
// R8 - Serial buffer needs no refresh
// R9 - Plain counter refresh: write high, select high
// R10 - Clearing refresh: writes high, select low
// R11 - Boundary refresh: write low, select high
// R12 - Device counter advances and wraps
module vram_refresh_ctrl #(
    parameter int ROW_INTERVAL = vram_refresh_pkg::ROW_INTERVAL_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic refresh_enable,
    input wire vram_refresh_pkg::refresh_mode_t refresh_mode,
    input wire logic [vram_refresh_pkg::BOUNDARY_WIDTH-1:0] boundary_code,
    input wire logic traffic_refresh,
    input wire logic hidden_request,
    output logic bus_grant,
    output logic refresh_busy,
    output vram_refresh_pkg::strobe_pins_t pins,
    output logic [vram_refresh_pkg::ROW_WIDTH-1:0] address,
    output logic [vram_refresh_pkg::ROW_WIDTH-1:0] row_pointer,
    output logic overdue
);
    localparam int TW = 8;
    localparam int IW = $clog2(ROW_INTERVAL + 1);

    // Sequence states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_PULSE = 3'h3,
        ST_PRECHARGE = 3'h2,
        ST_HIDDEN_HIGH = 3'h6
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    // Cycles until the next row is due
    logic [IW-1:0] interval_ff;
    // Refresh owed to the array
    logic pending_ff;
    logic overdue_ff;
    logic hidden_ff;
    vram_refresh_pkg::strobe_pins_t pins_ff;
    vram_refresh_pkg::strobe_pins_t nxt_pins;
    logic [vram_refresh_pkg::ROW_WIDTH-1:0] row_ff;
    logic [vram_refresh_pkg::ROW_WIDTH-1:0] addr_ff;
    logic [vram_refresh_pkg::ROW_WIDTH-1:0] nxt_addr;
    logic timer_load;
    logic [TW-1:0] timer_count;
    logic timer_done;

    // Wrapping increment used by the row mirror row_ff
    function automatic logic [vram_refresh_pkg::ROW_WIDTH-1:0] next_row(
        input logic [vram_refresh_pkg::ROW_WIDTH-1:0] r);
        next_row = (r == vram_refresh_pkg::ROW_WIDTH'(vram_refresh_pkg::ROW_COUNT - 1))
            ? '0 : r + vram_refresh_pkg::ROW_WIDTH'(1);
    endfunction : next_row

    phase_timer #(.WIDTH(TW)) u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .load(timer_load),
        .count(timer_count),
        .done(timer_done)
    );

    wire tick = (interval_ff == '0);
    // Live mode, so the column strobe and the pin code of one cycle always agree
    wire is_counter = (refresh_mode != vram_refresh_pkg::MODE_ROW_ONLY);
    wire start = (state_ff == ST_IDLE) && refresh_enable && pending_ff;
    // The user may start a hidden refresh only while holding a read open
    wire hidden_start = (state_ff == ST_IDLE) && refresh_enable && hidden_request;

    // R1 row pacing
    // One row falls due every interval; a second due while one is pending is late
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            interval_ff <= '0;
        else if (tick)
            interval_ff <= IW'(ROW_INTERVAL - 1);
        else
            interval_ff <= interval_ff - IW'(1);
    end

    // R2 traffic credit
    // A user row cycle stands in for the owed refresh; a new tick wins over credit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pending_ff <= 1'b0;
            overdue_ff <= 1'b0;
        end
        else
        begin
            if (tick)
                pending_ff <= 1'b1;
            else if (traffic_refresh || (state_ff == ST_PRECHARGE && timer_done))
                pending_ff <= 1'b0;
            if (tick && pending_ff)
                overdue_ff <= 1'b1;
            else if (!refresh_enable)
                overdue_ff <= 1'b0;
        end
    end

    // Phase sequencing of the strobes
    always_comb
    begin
        nxt_state = state_ff;
        nxt_pins = pins_ff;
        nxt_addr = addr_ff;
        timer_load = 1'b0;
        timer_count = '0;
        case (state_ff)
            ST_IDLE:
            begin
                if (hidden_start)
                begin
                    // R7 hidden refresh
                    // Keep column strobe and output enable low, lift row strobe
                    nxt_pins.row_strobe_n = 1'b1;
                    nxt_pins.column_strobe_n = 1'b0;
                    nxt_pins.transfer_or_output_enable_n = 1'b0;
                    // Plain counter code, so a hidden refresh changes no mode state
                    nxt_pins.upper_byte_write_n = 1'b1;
                    nxt_pins.lower_byte_write_n = 1'b1;
                    nxt_pins.function_select = 1'b1;
                    timer_load = 1'b1;
                    timer_count = TW'(vram_refresh_pkg::RAS_PRECHARGE_CYC);
                    nxt_state = ST_HIDDEN_HIGH;
                end
                else if (start)
                begin
                    nxt_pins = vram_refresh_pkg::PINS_IDLE;
                    if (is_counter)
                    begin
                        // R5 counter refresh
                        // Column strobe leads, no address needed
                        nxt_pins.column_strobe_n = 1'b0;
                    end
                    else
                    begin
                        // R3 row-only refresh
                        nxt_addr = row_ff;
                    end
                    // R9 plain counter refresh
                    // R10 clearing refresh
                    // R11 boundary refresh
                    nxt_pins.function_select = (refresh_mode != vram_refresh_pkg::MODE_CLEARING_COUNTER);
                    nxt_pins.upper_byte_write_n = (refresh_mode != vram_refresh_pkg::MODE_BOUNDARY_SETTING);
                    nxt_pins.lower_byte_write_n = (refresh_mode != vram_refresh_pkg::MODE_BOUNDARY_SETTING);
                    if (refresh_mode == vram_refresh_pkg::MODE_BOUNDARY_SETTING)
                        nxt_addr = {2'h0, boundary_code, 2'h0};
                    timer_load = 1'b1;
                    timer_count = TW'(vram_refresh_pkg::SETUP_CYC);
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP, ST_HIDDEN_HIGH:
            begin
                if (timer_done)
                begin
                    // R4 output enable high
                    // Row-only cycles keep output enable high at the fall
                    nxt_pins.row_strobe_n = 1'b0;
                    timer_load = 1'b1;
                    timer_count = TW'(vram_refresh_pkg::RAS_PULSE_CYC);
                    nxt_state = ST_PULSE;
                end
            end
            ST_PULSE:
            begin
                if (timer_done)
                begin
                    nxt_pins = vram_refresh_pkg::PINS_IDLE;
                    timer_load = 1'b1;
                    timer_count = TW'(vram_refresh_pkg::RAS_PRECHARGE_CYC);
                    nxt_state = ST_PRECHARGE;
                end
            end
            ST_PRECHARGE:
            begin
                if (timer_done)
                    nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_pins = vram_refresh_pkg::PINS_IDLE;
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State, pins and address registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= ST_IDLE;
            pins_ff <= vram_refresh_pkg::PINS_IDLE;
            addr_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            pins_ff <= nxt_pins;
            addr_ff <= nxt_addr;
        end
    end

    // Whether the cycle in flight is a hidden one
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hidden_ff <= 1'b0;
        else if (state_ff == ST_IDLE)
            hidden_ff <= hidden_start;
    end

    // R12 counter mirror
    // Row-only rows and the device counter advance in step; the mirror is a guess
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            row_ff <= '0;
        else if (state_ff == ST_PULSE && timer_done)
            row_ff <= next_row(row_ff);
    end

    // R6 outputs float
    // Bus is granted back only when idle; during counter cycles device data floats
    assign bus_grant = (state_ff == ST_IDLE) && !hidden_start && !start;
    // R8 serial buffer
    // No refresh is ever scheduled for the serial buffer
    assign refresh_busy = (state_ff != ST_IDLE) || hidden_ff;
    assign pins = pins_ff;
    assign address = addr_ff;
    assign row_pointer = row_ff;
    assign overdue = overdue_ff;
endmodule : vram_refresh_ctrl

// ---- vram_refresh_assertions.sv ----
`timescale 1ns/100ps
// Watches the strobe pins of the refresh controller
module vram_refresh_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic refresh_enable,
    input wire vram_refresh_pkg::refresh_mode_t refresh_mode,
    input wire logic [4:0] boundary_code,
    input wire logic hidden_request,
    input wire logic refresh_busy,
    input wire vram_refresh_pkg::strobe_pins_t pins,
    input wire logic [8:0] address
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Row strobe level at the last edge; resets high like the idle pin, so no false fall
    logic ras_prev_ff;
    logic [7:0] low_cnt_ff;
    // Row strobe fall with column strobe already low
    wire cbr_fall = ras_prev_ff && !pins.row_strobe_n && !pins.column_strobe_n;
    // Row strobe fall with column strobe high
    wire ras_only = ras_prev_ff && !pins.row_strobe_n && pins.column_strobe_n;
    // Both byte writes high
    wire writes_hi = pins.upper_byte_write_n && pins.lower_byte_write_n;
    // Counts sampled low cycles of the row strobe; a counter avoids a long repetition
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ras_prev_ff <= 1'b1;
            low_cnt_ff <= 8'h00;
        end
        else
        begin
            ras_prev_ff <= pins.row_strobe_n;
            low_cnt_ff <= pins.row_strobe_n ? 8'h00 : low_cnt_ff + 8'h01;
        end
    end
    ras_width_a: assert property ($rose(pins.row_strobe_n) |-> low_cnt_ff == vram_refresh_pkg::RAS_PULSE_CYC + 1)
        else $error("row strobe pulse width wrong");
    cas_high_a: assert property (ras_only |-> pins.column_strobe_n [*8])
        else $error("column strobe not held high");
    oe_high_a: assert property (ras_only |-> pins.transfer_or_output_enable_n)
        else $error("output enable low at row strobe fall");
    cbr_order_a: assert property (cbr_fall |-> !$past(pins.column_strobe_n))
        else $error("column strobe not before row strobe");
    plain_code_a: assert property (cbr_fall && refresh_mode == vram_refresh_pkg::MODE_PLAIN_COUNTER
        |-> writes_hi && pins.function_select)
        else $error("plain refresh pin code wrong");
    clear_code_a: assert property (cbr_fall && refresh_mode == vram_refresh_pkg::MODE_CLEARING_COUNTER
        |-> writes_hi && !pins.function_select)
        else $error("clearing refresh pin code wrong");
    bound_code_a: assert property (cbr_fall && refresh_mode == vram_refresh_pkg::MODE_BOUNDARY_SETTING
        |-> !writes_hi && pins.function_select && address[6:2] == boundary_code)
        else $error("boundary refresh pin code wrong");
    hidden_start_a: assert property ($rose(hidden_request) && !refresh_busy && refresh_enable
        |-> ##[1:11] cbr_fall)
        else $error("hidden refresh did not start");
endmodule : vram_refresh_checker
bind vram_refresh_ctrl vram_refresh_checker checker_i (.clk(clk), .arst_n(arst_n), .refresh_enable(refresh_enable),
    .refresh_mode(refresh_mode), .boundary_code(boundary_code), .hidden_request(hidden_request),
    .refresh_busy(refresh_busy), .pins(pins), .address(address));

// ---- vram_device_model.sv ----
`timescale 1ns/100ps
// Behavioural memory: decodes each row strobe fall, no clock of its own
module vram_device_model (
    input wire vram_refresh_pkg::strobe_pins_t pins,
    input wire logic [8:0] address,
    output logic [8:0] last_row_ff,
    output vram_refresh_pkg::refresh_mode_t last_kind_ff,
    output logic [4:0] boundary_ff
);
    logic [8:0] counter_ff = 9'h000;
    // serial buffer static
    // The serial buffer is not modelled: it needs no refresh at all
    initial
    begin
        last_row_ff = 9'h1FF;
        last_kind_ff = vram_refresh_pkg::MODE_ROW_ONLY;
        boundary_ff = 5'h1F;
    end
    always @(negedge pins.row_strobe_n)
    begin
        if (!pins.column_strobe_n)
        begin
            // Counter supplies the row and wraps after the last one
            last_row_ff = counter_ff;
            counter_ff = counter_ff + 9'h001;
            if (!pins.function_select)
                last_kind_ff = vram_refresh_pkg::MODE_CLEARING_COUNTER;
            else if (pins.upper_byte_write_n && pins.lower_byte_write_n)
                last_kind_ff = vram_refresh_pkg::MODE_PLAIN_COUNTER;
            else
                last_kind_ff = vram_refresh_pkg::MODE_BOUNDARY_SETTING;
            // Clearing restores the widest code, setting latches it
            if (!pins.function_select)
                boundary_ff = 5'h1F;
            else if (last_kind_ff == vram_refresh_pkg::MODE_BOUNDARY_SETTING)
                boundary_ff = address[6:2];
        end
        else if (pins.transfer_or_output_enable_n)
        begin
            last_row_ff = address;
            last_kind_ff = vram_refresh_pkg::MODE_ROW_ONLY;
        end
    end
endmodule : vram_device_model

// ---- testbench.sv ----
`timescale 1ns/100ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic refresh_enable = 1'b0;
    vram_refresh_pkg::refresh_mode_t refresh_mode = vram_refresh_pkg::MODE_ROW_ONLY;
    logic [4:0] boundary_code = 5'h00;
    logic traffic_refresh = 1'b0;
    logic hidden_request = 1'b0;
    logic refresh_busy;
    vram_refresh_pkg::strobe_pins_t pins;
    logic [8:0] address;
    logic [8:0] last_row_ff;
    vram_refresh_pkg::refresh_mode_t last_kind_ff;
    logic [4:0] boundary_ff;
    logic bus_grant;
    logic [8:0] row_pointer;
    logic overdue;
    int n_mismatch = 0;
    int tests_run = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    // Short interval keeps the run brief
    vram_refresh_ctrl #(.ROW_INTERVAL(40)) dut (.clk(clk), .arst_n(arst_n), .refresh_enable(refresh_enable),
        .refresh_mode(refresh_mode), .boundary_code(boundary_code), .traffic_refresh(traffic_refresh),
        .hidden_request(hidden_request), .bus_grant(bus_grant), .refresh_busy(refresh_busy), .pins(pins),
        .address(address), .row_pointer(row_pointer), .overdue(overdue));
    vram_device_model device (.pins(pins), .address(address), .last_row_ff(last_row_ff),
        .last_kind_ff(last_kind_ff), .boundary_ff(boundary_ff));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // Bounded wait for the controller to go idle
    task automatic wait_idle();
        int i;
        for (i = 0; i < 40 && refresh_busy !== 1'b0; i++) @(posedge clk) #1;
        if (i == 40)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_idle
    // Mode changes only while idle, so no refresh sees a half-changed code
    task automatic set_mode(input vram_refresh_pkg::refresh_mode_t m, input logic [4:0] code);
        @(posedge clk);
        refresh_enable <= 1'b0;
        repeat (2) @(posedge clk);
        wait_idle();
        @(posedge clk);
        refresh_mode <= m;
        boundary_code <= code;
        @(posedge clk);
        refresh_enable <= 1'b1;
    endtask : set_mode
    // Waits for the next row strobe fall, bounded
    task automatic await_refresh();
        int i;
        int j;
        for (i = 0; i < 300 && pins.row_strobe_n !== 1'b1; i++) @(posedge clk) #1;
        for (j = 0; j < 300 && pins.row_strobe_n !== 1'b0; j++) @(posedge clk) #1;
        if (i == 300 || j == 300)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask : await_refresh
    task automatic test_row_only();
        set_mode(vram_refresh_pkg::MODE_ROW_ONLY, 5'h00);
        await_refresh();
        `CHECK(last_kind_ff, vram_refresh_pkg::MODE_ROW_ONLY)
        `CHECK(last_row_ff, 9'h000)
        `CHECK(bus_grant, 1'b0)
        await_refresh();
        `CHECK(last_row_ff, 9'h001)
        `CHECK(row_pointer, 9'h001)
        $display("row-only test done");
    endtask : test_row_only
    task automatic test_counter_modes();
        vram_refresh_pkg::refresh_mode_t m;
        for (int k = 1; k < 4; k++)
        begin
            m = vram_refresh_pkg::refresh_mode_t'(k);
            set_mode(m, 5'h0F);
            await_refresh();
            `CHECK(last_kind_ff, m)
            `CHECK(boundary_ff, (k == 3) ? 5'h0F : 5'h1F)
        end
        $display("counter modes test done");
    endtask : test_counter_modes
    task automatic test_hidden();
        set_mode(vram_refresh_pkg::MODE_PLAIN_COUNTER, 5'h00);
        await_refresh();
        wait_idle();
        @(posedge clk);
        hidden_request <= 1'b1;
        @(posedge clk);
        hidden_request <= 1'b0;
        await_refresh();
        `CHECK(last_kind_ff, vram_refresh_pkg::MODE_PLAIN_COUNTER)
        `CHECK(pins.transfer_or_output_enable_n, 1'b0)
        $display("hidden test done");
    endtask : test_hidden
    // One refresh per interval while enabled
    task automatic test_interval();
        int n;
        logic prev;
        logic late;
        n = 0;
        late = 1'b0;
        prev = pins.row_strobe_n;
        repeat (400)
        begin
            @(posedge clk) #1;
            if (prev && !pins.row_strobe_n) n++;
            prev = pins.row_strobe_n;
            late = late | overdue;
        end
        `CHECK(n >= 9 && n <= 11, 1'b1)
        `CHECK(late, 1'b0)
        $display("interval test done");
    endtask : test_interval
    // With refresh held off, user row cycles keep a due row from going late
    task automatic test_traffic();
        int hits;
        hits = 0;
        @(posedge clk);
        refresh_enable <= 1'b0;
        traffic_refresh <= 1'b1;
        repeat (90)
        begin
            @(posedge clk) #1;
            if (overdue === 1'b1) hits++;
        end
        `CHECK(hits, 0)
        @(posedge clk);
        traffic_refresh <= 1'b0;
        repeat (90)
        begin
            @(posedge clk) #1;
            if (overdue === 1'b1) hits++;
        end
        `CHECK(hits > 0, 1'b1)
        $display("traffic test done");
    endtask : test_traffic
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        test_row_only();
        test_counter_modes();
        test_hidden();
        test_interval();
        test_traffic();
        print_verdict();
    end
endmodule : testbench
